// *** return_exec_pkg.sv ***
// Summary of operation
// - Upper byte 0000 1100 is a literal exit; its low byte goes to working.
// - A literal exit loads the program counter from the stack top.
// - Returns keep both pc latches, save the fast interrupt restore.
// - A literal exit takes two cycles: literal in Q2, pop and write in Q4.
// - Opcode 0000 0000 0001 001s pops the stack top into the pc, s fast.
// - A fast subroutine exit reloads working, flags and bank from shadows.
// - A plain subroutine exit leaves working, flags and bank untouched.
// - Subroutine and interrupt exits pop in Q4, then idle a second cycle.
// - A fast interrupt exit restores the whole context from a shadow set.
// - Opcode 0000 0000 0001 000s pops the pc and sets a global enable.
// - Main and low shadow sets exist; the exit picks by operating state.
package return_exec_pkg;
    localparam int LIT_W    = 8;
    localparam int OP_W     = 16;
    localparam int FAST_BIT = 0;
    localparam logic [7:0]  LIT_EXIT_HI  = 8'h0C;
    localparam logic [15:0] EXIT_MASK    = 16'hFFFE;
    localparam logic [15:0] SUB_EXIT_OP  = 16'h0012;
    localparam logic [15:0] INT_EXIT_OP  = 16'h0010;
    localparam logic [1:0]  Q1 = 2'h0;
    localparam logic [1:0]  Q2 = 2'h1;
    localparam logic [1:0]  Q3 = 2'h2;
    localparam logic [1:0]  Q4 = 2'h3;
    localparam logic [7:0]  BYTE_RESET = 8'h00;

    typedef enum logic [1:0] {K_NONE, K_LIT, K_SUB, K_INT} ret_kind_e;
    typedef enum logic [1:0] {S_IDLE, S_FIRST, S_SECOND} exec_e;

    // full restorable context, one byte per register
    typedef struct packed {
        logic [7:0] working;
        logic [7:0] flags;
        logic [7:0] bankSel;
        logic [7:0] pointer0High;
        logic [7:0] pointer0Low;
        logic [7:0] pointer1High;
        logic [7:0] pointer1Low;
        logic [7:0] pointer2High;
        logic [7:0] pointer2Low;
        logic [7:0] productHigh;
        logic [7:0] productLow;
        logic [7:0] pcHighLatch;
        logic [7:0] pcUpperLatch;
    } ctx_s;

    // opcode classes
    function automatic ret_kind_e decodeKind(input logic [15:0] op);
        if (op[15:LIT_W] == LIT_EXIT_HI) begin
            return K_LIT;
        end else if ((op & EXIT_MASK) == SUB_EXIT_OP) begin
            return K_SUB;
        end else if ((op & EXIT_MASK) == INT_EXIT_OP) begin
            return K_INT;
        end
        return K_NONE;
    endfunction
endpackage

// *** stack_if.sv ***
`timescale 1ns/1ps
interface stack_if #(
    parameter int W  = 21,
    parameter int PW = 5
);
    logic          push;
    logic          pop;
    logic [W-1:0]  pushData;
    logic [W-1:0]  top;
    logic [PW-1:0] ptr;

    modport ctl (output push, output pop, output pushData,
                 input top, input ptr);
    modport mem (input push, input pop, input pushData,
                 output top, output ptr);
endinterface

// *** return_stack.sv ***
`timescale 1ns/1ps
module return_stack #(
    parameter int W     = 21,
    parameter int DEPTH = 31,
    parameter int PW    = 5
) (
    input wire logic clk,
    input wire logic reset_n,
    stack_if.mem     sp
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] words;
        logic [PW-1:0]           ptr;
        logic [W-1:0]            top;
    } stk_s;

    stk_s q;
    stk_s d;

    // pop beats push; the top word is re-read into a register on each move
    always_comb begin
        d = q;
        if (sp.pop && q.ptr != '0) begin
            d.ptr = q.ptr - PW'(1);
            d.top = (q.ptr > PW'(1)) ? q.words[q.ptr - PW'(2)] : '0;
        end else if (sp.push && q.ptr < PW'(DEPTH)) begin
            d.words[q.ptr] = sp.pushData;
            d.ptr          = q.ptr + PW'(1);
            d.top          = sp.pushData;
        end
    end

    // register the whole stack state
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sp.top = q.top;
    assign sp.ptr = q.ptr;

    a_pop_dec: assert property (@(posedge clk) disable iff (!reset_n)
        sp.pop && q.ptr != '0 |=> q.ptr == $past(q.ptr) - PW'(1))
        else $error("pop did not lower the stack pointer");
    c_pop_seen: cover property (@(posedge clk) disable iff (!reset_n)
        sp.pop && q.ptr > PW'(1));
endmodule

// *** subroutine_return_execution.sv ***
`timescale 1ns/1ps
module subroutine_return_execution #(
    parameter int PC_W        = 21,
    parameter int STACK_DEPTH = 31
) (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic [15:0]           instr,
    input  wire logic                  instrValid,
    input  wire logic                  callPush,
    input  wire logic [PC_W-1:0]       callAddr,
    input  wire logic                  callSave,
    input  wire logic                  intSave,
    input  wire logic                  intSaveLow,
    input  wire logic                  returnToLow,
    input  wire logic                  servingHigh,
    input  wire logic                  intEntryHigh,
    input  wire logic                  intEntryLow,
    input  wire logic                  ctxLoad,
    input  return_exec_pkg::ctx_s      ctxIn,
    output logic [1:0]                 qPhase,
    output logic                       busy,
    output logic [PC_W-1:0]            pc,
    output return_exec_pkg::ctx_s      ctx,
    output logic                       gieHigh,
    output logic                       gieLow,
    output logic [$clog2(STACK_DEPTH+1)-1:0] stackDepth
);
    localparam int PW = $clog2(STACK_DEPTH + 1);

    typedef struct packed {
        logic [1:0]                 phase;
        return_exec_pkg::exec_e     fsm;
        return_exec_pkg::ret_kind_e kind;
        logic                       fast;
        logic [7:0]                 opLow;
        logic [7:0]                 lit;
        logic [PC_W-1:0]            pc;
        return_exec_pkg::ctx_s      ctx;
        logic [7:0]                 workingCall;
        logic [7:0]                 flagsCall;
        logic [7:0]                 bankCall;
        return_exec_pkg::ctx_s      shadowMain;
        return_exec_pkg::ctx_s      shadowLow;
        logic                       gieH;
        logic                       gieL;
    } st_s;

    st_s q;
    st_s d;

    stack_if #(.W(PC_W), .PW(PW)) stk ();

    return_stack #(.W(PC_W), .DEPTH(STACK_DEPTH), .PW(PW)) u_stack (
        .clk     (clk),
        .reset_n (reset_n),
        .sp      (stk.mem)
    );

    return_exec_pkg::ret_kind_e issueKind;
    logic issue;
    logic quiet;
    logic popNow;

    // a return is taken only at Q1 of an idle core; other opcodes pass by
    assign issueKind = return_exec_pkg::decodeKind(instr);
    assign issue  = instrValid && q.fsm == return_exec_pkg::S_IDLE &&
                    q.phase == return_exec_pkg::Q1 &&
                    issueKind != return_exec_pkg::K_NONE;
    assign quiet  = q.fsm == return_exec_pkg::S_IDLE && !issue;
    assign popNow = q.fsm == return_exec_pkg::S_FIRST &&
                    q.phase == return_exec_pkg::Q4;

    // stack pops happen only in Q4 of the first cycle of a return
    assign stk.pop      = popNow;
    assign stk.push     = callPush && !popNow;
    assign stk.pushData = callAddr;

    // next state: phase counter, sequencer and context updates
    always_comb begin
        d = q;
        d.phase = q.phase + 2'h1;
        // disable on interrupt entry; a re-enable below wins the same cycle
        if (intEntryHigh) begin
            d.gieH = 1'b0;
        end
        if (intEntryLow) begin
            d.gieL = 1'b0;
        end
        // side loads are held off while a return runs, so a return never
        // races a context write from outside
        if (quiet && ctxLoad) begin
            d.ctx = ctxIn;
        end
        if (quiet && callSave) begin
            d.workingCall = q.ctx.working;
            d.flagsCall   = q.ctx.flags;
            d.bankCall    = q.ctx.bankSel;
        end
        if (quiet && intSave) begin
            if (intSaveLow) begin
                d.shadowLow = q.ctx;
            end else begin
                d.shadowMain = q.ctx;
            end
        end
        case (q.fsm)
            return_exec_pkg::S_IDLE: begin
                if (issue) begin
                    d.fsm   = return_exec_pkg::S_FIRST;
                    d.kind  = issueKind;
                    d.fast  = instr[return_exec_pkg::FAST_BIT];
                    d.opLow = instr[return_exec_pkg::LIT_W-1:0];
                end
            end
            return_exec_pkg::S_FIRST: begin
                if (q.phase == return_exec_pkg::Q2 &&
                    q.kind == return_exec_pkg::K_LIT) begin
                    d.lit = q.opLow;
                end
                if (popNow) begin
                    d.fsm = return_exec_pkg::S_SECOND;
                    d.pc  = stk.top;
                    case (q.kind)
                        return_exec_pkg::K_LIT: begin
                            d.ctx.working = q.lit;
                        end
                        return_exec_pkg::K_SUB: begin
                            if (q.fast) begin
                                d.ctx.working = q.workingCall;
                                d.ctx.flags   = q.flagsCall;
                                d.ctx.bankSel = q.bankCall;
                            end
                        end
                        return_exec_pkg::K_INT: begin
                            if (q.fast) begin
                                d.ctx = returnToLow ? q.shadowLow
                                                    : q.shadowMain;
                            end
                            if (servingHigh) begin
                                d.gieH = 1'b1;
                            end else begin
                                d.gieL = 1'b1;
                            end
                        end
                        default: begin
                            d.fsm = return_exec_pkg::S_SECOND;
                        end
                    endcase
                end
            end
            return_exec_pkg::S_SECOND: begin
                // idle cycle, nothing but the sequencer moves
                if (q.phase == return_exec_pkg::Q4) begin
                    d.fsm = return_exec_pkg::S_IDLE;
                end
            end
            default: begin
                d.fsm = return_exec_pkg::S_IDLE;
            end
        endcase
    end

    // single state register; latches are never written by a return
    // outside the interrupt fast restore
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q      <= '0;
            q.fsm  <= return_exec_pkg::S_IDLE;
            q.kind <= return_exec_pkg::K_NONE;
        end else begin
            q <= d;
        end
    end

    assign qPhase     = q.phase;
    assign busy       = q.fsm != return_exec_pkg::S_IDLE;
    assign pc         = q.pc;
    assign ctx        = q.ctx;
    assign gieHigh    = q.gieH;
    assign gieLow     = q.gieL;
    assign stackDepth = stk.ptr;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_lit_w;
        logic [7:0] v;
        (issue && issueKind == return_exec_pkg::K_LIT,
         v = instr[return_exec_pkg::LIT_W-1:0]) |-> ##4 ctx.working == v;
    endproperty
    a_lit_w_load: assert property (p_lit_w)
        else $error("literal exit did not load the working register");

    a_pop_to_pc: assert property (popNow |=> pc == $past(stk.top))
        else $error("pc not loaded from the stack top");

    a_latch_kept: assert property (popNow &&
        !(q.kind == return_exec_pkg::K_INT && q.fast) |=>
        $stable(ctx.pcHighLatch) && $stable(ctx.pcUpperLatch))
        else $error("return changed a pc latch");

    a_two_cycles: assert property (issue |=> busy [*7] ##1 !busy)
        else $error("return did not take two instruction cycles");

    a_pop_at_q4: assert property (issue |-> ##3
        (stk.pop && qPhase == return_exec_pkg::Q4))
        else $error("pop not in Q4 of the first cycle");

    property p_sub_fast;
        logic [7:0] w;
        (popNow && q.kind == return_exec_pkg::K_SUB && q.fast,
         w = q.workingCall) |=> ctx.working == w &&
        ctx.flags == $past(q.flagsCall) &&
        ctx.bankSel == $past(q.bankCall);
    endproperty
    a_sub_fast: assert property (p_sub_fast)
        else $error("fast subroutine exit did not restore call shadows");

    a_sub_plain: assert property (popNow &&
        q.kind == return_exec_pkg::K_SUB && !q.fast |=>
        $stable(ctx))
        else $error("plain subroutine exit changed context");

    a_int_restore: assert property (popNow &&
        q.kind == return_exec_pkg::K_INT && q.fast |=>
        ctx == ($past(returnToLow) ? $past(q.shadowLow)
                                   : $past(q.shadowMain)))
        else $error("interrupt exit restored the wrong shadow set");

    a_gie_set: assert property (popNow &&
        q.kind == return_exec_pkg::K_INT |=>
        ($past(servingHigh) ? gieHigh : gieLow))
        else $error("interrupt exit did not set the global enable");

    c_lit_exit: cover property (issue && issueKind == return_exec_pkg::K_LIT);
    c_sub_fast: cover property (issue && issueKind == return_exec_pkg::K_SUB
        && instr[return_exec_pkg::FAST_BIT]);
    c_int_low:  cover property (popNow && q.kind == return_exec_pkg::K_INT
        && q.fast && returnToLow);
    c_back2back: cover property (issue ##8 issue);
endmodule

// *** subroutine_return_execution_tb.sv ***
`timescale 1ns/1ps
module subroutine_return_execution_tb;
    localparam int PC_W  = 21;
    localparam int DEPTH = 31;

    logic                    clk;
    logic                    reset_n;
    logic [15:0]             instr;
    logic                    instrValid;
    logic                    callPush;
    logic [PC_W-1:0]         callAddr;
    logic                    callSave;
    logic                    intSave;
    logic                    intSaveLow;
    logic                    returnToLow;
    logic                    servingHigh;
    logic                    intEntryHigh;
    logic                    intEntryLow;
    logic                    ctxLoad;
    return_exec_pkg::ctx_s   ctxIn;
    logic [1:0]              qPhase;
    logic                    busy;
    logic [PC_W-1:0]         pc;
    return_exec_pkg::ctx_s   ctx;
    logic                    gieHigh;
    logic                    gieLow;
    logic [4:0]              stackDepth;
    int                      errCount;
    int                      nTests;

    subroutine_return_execution #(.PC_W(PC_W), .STACK_DEPTH(DEPTH))
        i_subroutine_return_execution (
        .clk(clk), .reset_n(reset_n), .instr(instr),
        .instrValid(instrValid), .callPush(callPush),
        .callAddr(callAddr), .callSave(callSave), .intSave(intSave),
        .intSaveLow(intSaveLow), .returnToLow(returnToLow),
        .servingHigh(servingHigh), .intEntryHigh(intEntryHigh),
        .intEntryLow(intEntryLow), .ctxLoad(ctxLoad), .ctxIn(ctxIn),
        .qPhase(qPhase), .busy(busy), .pc(pc), .ctx(ctx),
        .gieHigh(gieHigh), .gieLow(gieLow), .stackDepth(stackDepth));

    // free-running 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic testDone;
        if (errCount == 0 && nTests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [103:0] seen, input logic [103:0] exp,
                         input string what);
        nTests++;
        if (seen !== exp) begin
            errCount++;
            $display("mismatch at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask

    // inputs move a fixed 2 ns after the rising edge, away from sampling
    task automatic tick;
        @(posedge clk);
        #2;
    endtask

    // distinct byte in every field so a wrong source shows up
    function automatic return_exec_pkg::ctx_s mk(input logic [7:0] seed);
        return_exec_pkg::ctx_s c;
        for (int i = 0; i < 13; i++) begin
            c[8*i +: 8] = seed + 8'(i);
        end
        return c;
    endfunction

    // an idle edge after each push keeps two pushes from touching the
    // strobe twice in one time step
    task automatic push(input logic [PC_W-1:0] a);
        callAddr = a;
        callPush = 1'b1;
        tick();
        callPush = 1'b0;
        tick();
    endtask

    task automatic loadCtx(input return_exec_pkg::ctx_s c);
        ctxIn   = c;
        ctxLoad = 1'b1;
        tick();
        ctxLoad = 1'b0;
    endtask

    task automatic saveInt(input logic low);
        intSaveLow = low;
        intSave    = 1'b1;
        tick();
        intSave    = 1'b0;
    endtask

    // issue in a Q1 cycle, then count busy cycles; results settle after
    task automatic issueOp(input logic [15:0] op, input bit taken);
        int n;
        int guard;
        guard = 0;
        while (qPhase !== 2'h0 || busy !== 1'b0) begin
            tick();
            guard++;
            if (guard > 20) begin
                errCount++;
                testDone();
            end
        end
        instr      = op;
        instrValid = 1'b1;
        tick();
        instrValid = 1'b0;
        check(qPhase, 2'h1, "phase after issue");
        n = 0;
        while (busy === 1'b1 && n < 12) begin
            tick();
            n++;
        end
        check(104'(n), taken ? 104'h7 : 104'h0, "busy cycles");
    endtask

    task automatic testLiteral;
        return_exec_pkg::ctx_s a;
        a = mk(8'h10);
        loadCtx(a);
        push(21'h1_2345);
        push(21'h0_ABCD);
        check(stackDepth, 5'h2, "depth after pushes");
        issueOp(16'h0C5A, 1'b1);
        a.working = 8'h5A;
        check(pc, 21'h0_ABCD, "literal pc");
        check(ctx, a, "literal ctx");
        check(stackDepth, 5'h1, "literal depth");
        issueOp(16'h0CFF, 1'b1);
        a.working = 8'hFF;
        check(pc, 21'h1_2345, "second literal pc");
        check(ctx, a, "second literal ctx");
        check(stackDepth, 5'h0, "empty depth");
    endtask

    task automatic testSub;
        return_exec_pkg::ctx_s a;
        return_exec_pkg::ctx_s b;
        a = mk(8'h40);
        b = mk(8'h80);
        loadCtx(a);
        callSave = 1'b1;
        tick();
        callSave = 1'b0;
        loadCtx(b);
        push(21'h0_0777);
        issueOp(16'h0012, 1'b1);
        check(pc, 21'h0_0777, "sub pc");
        check(ctx, b, "sub slow ctx");
        push(21'h1_F00E);
        issueOp(16'h0013, 1'b1);
        b.working = a.working;
        b.flags   = a.flags;
        b.bankSel = a.bankSel;
        check(pc, 21'h1_F00E, "sub fast pc");
        check(ctx, b, "sub fast ctx");
        check(stackDepth, 5'h0, "sub depth");
    endtask

    task automatic testInt;
        return_exec_pkg::ctx_s lowSet;
        return_exec_pkg::ctx_s mainSet;
        lowSet  = mk(8'hA0);
        mainSet = mk(8'hC0);
        loadCtx(lowSet);
        saveInt(1'b1);
        loadCtx(mainSet);
        saveInt(1'b0);
        loadCtx(mk(8'h20));
        push(21'h0_1111);
        push(21'h0_2222);
        returnToLow = 1'b1;
        servingHigh = 1'b1;
        issueOp(16'h0011, 1'b1);
        check(pc, 21'h0_2222, "int pc");
        check(ctx, lowSet, "int low set");
        check({gieHigh, gieLow}, 2'b10, "gie high set");
        returnToLow = 1'b0;
        servingHigh = 1'b0;
        issueOp(16'h0011, 1'b1);
        check(pc, 21'h0_1111, "int second pc");
        check(ctx, mainSet, "int main set");
        check({gieHigh, gieLow}, 2'b11, "gie low set");
        intEntryHigh = 1'b1;
        intEntryLow  = 1'b1;
        tick();
        intEntryHigh = 1'b0;
        intEntryLow  = 1'b0;
        check({gieHigh, gieLow}, 2'b00, "gie cleared");
        push(21'h0_3333);
        servingHigh = 1'b1;
        issueOp(16'h0010, 1'b1);
        check(pc, 21'h0_3333, "int slow pc");
        check(ctx, mainSet, "int slow ctx");
        check({gieHigh, gieLow}, 2'b10, "gie slow");
    endtask

    // neighbouring opcodes are not returns and must leave all state alone
    task automatic testOther;
        push(21'h0_4444);
        issueOp(16'h0014, 1'b0);
        issueOp(16'h0D00, 1'b0);
        check(pc, 21'h0_3333, "non-return pc");
        check(stackDepth, 5'h1, "non-return depth");
    endtask

    initial begin
        errCount     = 0;
        nTests       = 0;
        reset_n      = 1'b0;
        instr        = 16'h0000;
        instrValid   = 1'b0;
        callPush     = 1'b0;
        callAddr     = '0;
        callSave     = 1'b0;
        intSave      = 1'b0;
        intSaveLow   = 1'b0;
        returnToLow  = 1'b0;
        servingHigh  = 1'b0;
        intEntryHigh = 1'b0;
        intEntryLow  = 1'b0;
        ctxLoad      = 1'b0;
        ctxIn        = '0;
        repeat (8) @(posedge clk);
        #2;
        reset_n = 1'b1;
        check(pc, 21'h0_0000, "reset pc");
        check(ctx, 104'h0, "reset ctx");
        check(stackDepth, 5'h0, "reset depth");
        check(qPhase, 2'h0, "reset phase");
        testLiteral();
        testSub();
        testInt();
        testOther();
        testDone();
    end
endmodule
